// ===== cilc_pkg.sv
// shared constants, types and scrambler step of the conditional-invert line codec
package cilc_pkg;
  localparam int              FRAME_BITS     = 20;
  localparam logic [4:0]      LAST_BIT       = 5'h13;
  localparam logic [4:0]      HALF_ONES      = 5'h0A;
  localparam logic [4:0]      FRAME_ONES     = 5'h14;
  localparam logic [7:0]      FRAME_DISP     = 8'h14;
  localparam logic [7:0]      DISP_RESET     = 8'h00;
  localparam logic [1:0]      DIV1_LAST      = 2'h0;
  localparam logic [1:0]      DIV2_LAST      = 2'h1;
  localparam logic [1:0]      DIV4_LAST      = 2'h3;
  localparam logic [1:0]      RANGE_DIV2     = 2'h1;
  localparam logic [1:0]      RANGE_DIV4     = 2'h2;
  localparam logic [1:0]      RANGE_TEST     = 2'h3;
  // coding fields held as c0 c1 c2 c3, c0 in the msb
  localparam logic [3:0]      CF_DATA_F0     = 4'hD;
  localparam logic [3:0]      CF_DATA_F1     = 4'hB;
  localparam logic [3:0]      CF_DATA_INV_F0 = 4'h2;
  localparam logic [3:0]      CF_DATA_INV_F1 = 4'h4;
  localparam logic [3:0]      CF_CTRL_F0     = 4'h3;
  localparam logic [3:0]      CF_CTRL_F1     = 4'h5;
  localparam logic [3:0]      CF_CTRL_INV_F0 = 4'hC;
  localparam logic [3:0]      CF_CTRL_INV_F1 = 4'hA;
  // centre bits held as {w7, w8}
  localparam logic [1:0]      MID_CTRL_TRUE  = 2'h1;
  localparam logic [1:0]      MID_CTRL_INV   = 2'h2;
  // word fields with w0 in bit 0
  localparam logic [15:0]     IDLE_A_FIELD   = 16'h01FF;
  localparam logic [15:0]     IDLE_B_FIELD   = 16'h007F;
  localparam int              SCR_W          = 7;
  localparam logic [SCR_W-1:0] SCR_SEED      = 7'h7F;
  localparam logic [3:0]      LOCK_LAST_EDGE = 4'h7;
  localparam logic [7:0]      ADDR_CTRL      = 8'h00;
  localparam logic [7:0]      ADDR_STATUS    = 8'h04;
  localparam logic [7:0]      CTRL_RESET     = 8'h00;
  localparam int              CTRL_ENH       = 0;
  localparam int              CTRL_UFLAG     = 1;
  localparam int              CTRL_EXTCLK    = 2;
  localparam int              CTRL_TXR_LSB   = 4;
  localparam int              CTRL_RXR_LSB   = 6;
  localparam int              ST_LOCKED      = 0;
  localparam int              ST_ACC_SIGN    = 1;
  localparam int              ST_DATA        = 2;
  localparam int              ST_CTRL        = 3;
  localparam int              ST_ERR         = 4;

  typedef enum logic {
    CILC_LK_FREQ  = 1'b0,
    CILC_LK_PHASE = 1'b1
  } cilc_lock_t;

  function automatic logic [SCR_W-1:0] cilc_scr_next(input logic [SCR_W-1:0] s);
    cilc_scr_next = {s[SCR_W-2:0], s[6] ^ s[5]};
  endfunction : cilc_scr_next
endpackage : cilc_pkg

// ===== cilc_sync2.sv
// two-flop synchroniser for pins from outside the system clock
module cilc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : cilc_sync2

// ===== cilc_range_div.sv
// range divider turning source ticks into serial bit ticks
module cilc_range_div (
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic src_tick_in,
  input  wire logic div_four_in,
  input  wire logic div_two_in,
  input  wire logic realign_in,
  output logic      tick_out
);
  logic [1:0] count;
  // divide by four wins over divide by two
  wire logic [1:0] last_count = div_four_in ? cilc_pkg::DIV4_LAST
                              : (div_two_in ? cilc_pkg::DIV2_LAST : cilc_pkg::DIV1_LAST);
  wire logic       at_last    = (count == last_count);

  assign tick_out = src_tick_in && at_last;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || realign_in) begin
      count <= 2'h0;
    end else if (src_tick_in) begin
      count <= at_last ? 2'h0 : count + 2'h1;
    end
  end
endmodule : cilc_range_div

// ===== cilc_codec.sv
// line codec top: apb control, encoder, serialiser, deserialiser and decoder
// Overview of operation
// R1: inputs and qualifiers are captured at the internal word-rate strobe.
// R2: each word is a 16-bit word field then a 4-bit coding field.
// R3: enhanced data coding 1101/0010 with flag 0, 1011/0100 with flag 1.
// R4: control word splits payload around w7/w8 forced 01 true, 10 inverted.
// R5: idle A is nine ones then seven zeros, idle B seven then nine.
// R6: idle A when accumulated sign low, idle B when it is high.
// R7: invert the word when its sign equals the accumulated sign.
// R8: idle words are never inverted.
// R9: user flag on and enhanced off: odd/even bit follows the extra input.
// R10: user flag off: odd/even bit toggles on each data word.
// R11: enhanced mode scrambles the flag; user sees it for data words only.
// R12: enhanced mode scrambles and descrambles word bit w0.
// R13: both ends use the same seeded scrambler sequence, one step per word.
// R14: serial bit clock derives from the local oscillator in normal mode.
// R15: external serial clock select takes the word clock pin as serial clock.
// R16: transmit range divides by 1, 2 or 4 (upper bit set gives 4).
// R17: receive range 11 selects the test serial clock, else divide 1, 2, 4.
// R18: lock to the reference first, only then track the incoming bits.
// R19: word type comes from the coding field plus centre bits w7 and w8.
// R20: inverted data and control words are inverted back.
// R21: control payload is realigned onto output bits 0 to 13.
// R22: data and control indicators; idle shows all three indicators low.
// R23: error when c1c2 is 00 or 11, or 1100 with w7 low or w7w8 11.
// R24: idle words are sent when neither data nor control valid is high.
// R25: bits go out w0 first through w15, then c0 through c3.
// R26: without enhanced mode control and idle carry no flag, 0011 or 1100.
//
// Local design decisions: the register offsets and the APB slave port.
module cilc_codec (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [15:0] tx_data_in,
  input  wire logic        tx_data_word_valid_in,
  input  wire logic        tx_control_word_valid_in,
  input  wire logic        tx_extra_bit_in,
  input  wire logic        tx_word_clock_in,
  output logic             tx_word_strobe_out,
  output logic             serial_line_out,
  input  wire logic        serial_line_in,
  input  wire logic        local_reference_clock_in,
  input  wire logic        rx_test_serial_clock_in,
  output logic      [15:0] rx_data_out,
  output logic             rx_flag_out,
  output logic             rx_data_word_flag_out,
  output logic             rx_control_word_flag_out,
  output logic             rx_code_error_flag_out,
  output logic             rx_word_strobe_out,
  output logic             rx_locked_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  // control register fields
  logic [7:0] ctrl;
  wire logic       enhanced_simplex_enable = ctrl[cilc_pkg::CTRL_ENH];
  wire logic       tx_user_flag_enable     = ctrl[cilc_pkg::CTRL_UFLAG];
  wire logic       ext_serial_clock_select = ctrl[cilc_pkg::CTRL_EXTCLK];
  wire logic [1:0] tx_range_select         = ctrl[cilc_pkg::CTRL_TXR_LSB +: 2];
  wire logic [1:0] rx_range_select         = ctrl[cilc_pkg::CTRL_RXR_LSB +: 2];

  // pins: 0 word clock, 1 test clock, 2 reference clock, 3 serial line
  logic [3:0] pins_sync;
  logic [3:0] pins_prev;
  cilc_sync2 #(.WIDTH(4)) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   ({serial_line_in, local_reference_clock_in, rx_test_serial_clock_in, tx_word_clock_in}),
    .sync_out   (pins_sync)
  );
  wire logic tx_ext_rise  = pins_sync[0] && !pins_prev[0];
  wire logic rx_test_rise = pins_sync[1] && !pins_prev[1];
  wire logic rx_ref_rise  = pins_sync[2] && !pins_prev[2];
  wire logic rx_line      = pins_sync[3];
  wire logic rx_line_edge = pins_sync[3] ^ pins_prev[3];

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  // transmit bit timing; external clock mode only sees pin edges, so it is slow
  logic tx_bit_tick;
  wire logic tx_src_tick = ext_serial_clock_select ? tx_ext_rise : 1'b1; // R14 R15
  cilc_range_div u_tx_div (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .src_tick_in (tx_src_tick),
    .div_four_in (tx_range_select[1]), // R16
    .div_two_in  (tx_range_select[0]),
    .realign_in  (1'b0),
    .tick_out    (tx_bit_tick)
  );

  logic [4:0]  tx_bit_count;
  logic [19:0] tx_shift;
  logic [7:0]  tx_disp;
  logic [6:0]  tx_scr;
  logic        tx_toggle;
  logic        tx_last_idle;
  logic        tx_last_invert;

  // no strobe while reset holds the encoder, so nothing outside sees a load that never happens
  wire logic tx_load     = tx_bit_tick && (tx_bit_count == cilc_pkg::LAST_BIT) && !reset_in;
  // data valid wins if both qualifiers are high
  wire logic tx_sel_data = tx_data_word_valid_in;
  wire logic tx_sel_ctrl = !tx_data_word_valid_in && tx_control_word_valid_in;
  wire logic tx_sel_idle = !tx_data_word_valid_in && !tx_control_word_valid_in; // R24

  wire logic accumulated_sign = !tx_disp[7] && (tx_disp != cilc_pkg::DISP_RESET);
  wire logic tx_flag_plain = tx_user_flag_enable ? tx_extra_bit_in : tx_toggle; // R9 R10
  wire logic tx_flag_raw   = tx_sel_data && tx_flag_plain;
  wire logic tx_flag       = enhanced_simplex_enable ? (tx_flag_raw ^ tx_scr[0]) : tx_flag_raw; // R11 R13

  wire logic [15:0] tx_ctrl_field = {tx_data_in[13:7], cilc_pkg::MID_CTRL_TRUE[0],
                                     cilc_pkg::MID_CTRL_TRUE[1], tx_data_in[6:0]}; // R4
  wire logic [15:0] tx_idle_field = accumulated_sign ? cilc_pkg::IDLE_B_FIELD : cilc_pkg::IDLE_A_FIELD; // R5 R6
  wire logic [15:0] tx_field_plain = tx_sel_data ? tx_data_in : (tx_sel_ctrl ? tx_ctrl_field : tx_idle_field);
  wire logic [15:0] tx_field = {tx_field_plain[15:1],
                                tx_field_plain[0] ^ (enhanced_simplex_enable && tx_scr[1])}; // R12
  wire logic [3:0]  tx_cf = tx_sel_data ? (tx_flag ? cilc_pkg::CF_DATA_F1 : cilc_pkg::CF_DATA_F0)
                          : (tx_flag ? cilc_pkg::CF_CTRL_F1 : cilc_pkg::CF_CTRL_F0); // R3 R26
  wire logic [19:0] tx_true = {tx_cf[0], tx_cf[1], tx_cf[2], tx_cf[3], tx_field}; // R2 R25

  wire logic [4:0]  tx_ones      = 5'($countones(tx_true));
  wire logic        tx_word_sign = tx_ones > cilc_pkg::HALF_ONES;
  wire logic        tx_invert    = !tx_sel_idle && (tx_word_sign == accumulated_sign); // R7 R8
  wire logic [19:0] tx_sent      = tx_invert ? ~tx_true : tx_true;
  wire logic [4:0]  tx_ones_sent = tx_invert ? (cilc_pkg::FRAME_ONES - tx_ones) : tx_ones;
  // running disparity, ones minus zeros; stays small because every word corrects it
  wire logic [7:0]  next_tx_disp = tx_disp + {2'h0, tx_ones_sent, 1'b0} - cilc_pkg::FRAME_DISP;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_bit_count   <= cilc_pkg::LAST_BIT;
      tx_shift       <= '0;
      tx_disp        <= cilc_pkg::DISP_RESET;
      tx_scr         <= cilc_pkg::SCR_SEED;
      tx_toggle      <= 1'b0;
      tx_last_idle   <= 1'b1;
      tx_last_invert <= 1'b0;
    end else if (tx_load) begin // R1
      tx_bit_count   <= 5'h00;
      tx_shift       <= tx_sent;
      tx_disp        <= next_tx_disp;
      tx_scr         <= cilc_pkg::cilc_scr_next(tx_scr); // R13
      tx_toggle      <= tx_toggle ^ (tx_sel_data && !tx_user_flag_enable); // R10
      tx_last_idle   <= tx_sel_idle;
      tx_last_invert <= tx_invert;
    end else if (tx_bit_tick) begin
      tx_bit_count   <= tx_bit_count + 5'h01;
      tx_shift       <= {1'b0, tx_shift[19:1]}; // R25
    end
  end

  assign serial_line_out    = tx_shift[0];
  assign tx_word_strobe_out = tx_load;

  // receive lock: frequency first, phase tracking only once locked
  cilc_pkg::cilc_lock_t rx_lock_state;
  cilc_pkg::cilc_lock_t next_rx_lock_state;
  logic [3:0] rx_ref_count;
  wire logic rx_locked = (rx_lock_state == cilc_pkg::CILC_LK_PHASE);

  always_comb begin
    case (rx_lock_state)
      cilc_pkg::CILC_LK_FREQ: begin
        next_rx_lock_state = (rx_ref_rise && rx_ref_count == cilc_pkg::LOCK_LAST_EDGE)
                           ? cilc_pkg::CILC_LK_PHASE : cilc_pkg::CILC_LK_FREQ; // R18
      end
      cilc_pkg::CILC_LK_PHASE: begin
        next_rx_lock_state = cilc_pkg::CILC_LK_PHASE;
      end
      default: begin
        next_rx_lock_state = cilc_pkg::CILC_LK_FREQ;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_lock_state <= cilc_pkg::CILC_LK_FREQ;
      rx_ref_count  <= 4'h0;
    end else begin
      rx_lock_state <= next_rx_lock_state;
      rx_ref_count  <= (rx_ref_rise && !rx_locked) ? rx_ref_count + 4'h1 : rx_ref_count;
    end
  end

  // receive bit timing; line edges re-centre the divider once locked
  logic rx_bit_tick;
  wire logic rx_src_tick = (rx_range_select == cilc_pkg::RANGE_TEST) ? rx_test_rise : 1'b1; // R17
  cilc_range_div u_rx_div (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .src_tick_in (rx_src_tick),
    .div_four_in (rx_range_select == cilc_pkg::RANGE_DIV4),
    .div_two_in  (rx_range_select == cilc_pkg::RANGE_DIV2),
    .realign_in  (rx_locked && rx_line_edge), // R18
    .tick_out    (rx_bit_tick)
  );
  wire logic rx_sample = rx_bit_tick && rx_locked; // R18

  // deserialiser; word boundary is the first bit sampled after lock
  logic [19:0] rx_shift;
  logic [4:0]  rx_bit_count;
  logic [6:0]  rx_scr;
  wire logic [19:0] rx_frame     = {rx_line, rx_shift[19:1]};
  wire logic        rx_word_done = rx_sample && (rx_bit_count == cilc_pkg::LAST_BIT);

  // coding field decode
  wire logic [3:0] rx_cf  = {rx_frame[16], rx_frame[17], rx_frame[18], rx_frame[19]}; // R19
  wire logic [1:0] rx_mid = {rx_frame[7], rx_frame[8]}; // R19
  wire logic rx_bad_c12   = (rx_cf[2] == rx_cf[1]); // R23
  wire logic rx_cf_true0  = (rx_cf == cilc_pkg::CF_CTRL_F0);
  wire logic rx_cf_true1  = enhanced_simplex_enable && (rx_cf == cilc_pkg::CF_CTRL_F1);
  wire logic rx_cf_inv0   = (rx_cf == cilc_pkg::CF_CTRL_INV_F0);
  wire logic rx_cf_inv1   = enhanced_simplex_enable && (rx_cf == cilc_pkg::CF_CTRL_INV_F1);
  wire logic rx_data_inv  = (rx_cf == cilc_pkg::CF_DATA_INV_F0) || (rx_cf == cilc_pkg::CF_DATA_INV_F1);
  wire logic rx_is_data   = rx_data_inv || (rx_cf == cilc_pkg::CF_DATA_F0) || (rx_cf == cilc_pkg::CF_DATA_F1);
  wire logic rx_ctrl_true = (rx_cf_true0 || rx_cf_true1) && (rx_mid == cilc_pkg::MID_CTRL_TRUE);
  wire logic rx_ctrl_inv  = (rx_cf_inv0 || rx_cf_inv1) && (rx_mid == cilc_pkg::MID_CTRL_INV); // R23
  wire logic rx_is_ctrl   = rx_ctrl_true || rx_ctrl_inv;
  wire logic rx_is_idle   = (rx_cf_true0 || rx_cf_true1) && !rx_ctrl_true;
  wire logic rx_is_err    = !rx_is_data && !rx_is_ctrl && !rx_is_idle; // R23
  wire logic rx_inverted  = rx_data_inv || rx_ctrl_inv;
  wire logic rx_flag_line = (rx_cf == cilc_pkg::CF_DATA_F1) || (rx_cf == cilc_pkg::CF_DATA_INV_F1);
  wire logic rx_flag      = enhanced_simplex_enable ? (rx_flag_line ^ rx_scr[0]) : rx_flag_line; // R11 R13

  // word field decode
  wire logic [15:0] rx_field_raw = rx_inverted ? ~rx_frame[15:0] : rx_frame[15:0]; // R20
  wire logic [15:0] rx_field = {rx_field_raw[15:1],
                                rx_field_raw[0] ^ (enhanced_simplex_enable && rx_scr[1])}; // R12
  wire logic [15:0] rx_ctrl_word = {2'h0, rx_field[15:9], rx_field[6:0]}; // R21
  wire logic [15:0] rx_word_out  = rx_is_data ? rx_field : (rx_is_ctrl ? rx_ctrl_word : 16'h0000);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_shift     <= '0;
      rx_bit_count <= 5'h00;
    end else if (rx_sample) begin
      rx_shift     <= rx_frame;
      rx_bit_count <= rx_word_done ? 5'h00 : rx_bit_count + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_scr                   <= cilc_pkg::SCR_SEED;
      rx_data_out              <= 16'h0000;
      rx_flag_out              <= 1'b0;
      rx_data_word_flag_out    <= 1'b0;
      rx_control_word_flag_out <= 1'b0;
      rx_code_error_flag_out   <= 1'b0;
    end else if (rx_word_done) begin
      rx_scr                   <= cilc_pkg::cilc_scr_next(rx_scr); // R13
      rx_data_out              <= rx_word_out;
      rx_flag_out              <= rx_is_data && rx_flag; // R11
      rx_data_word_flag_out    <= rx_is_data; // R22
      rx_control_word_flag_out <= rx_is_ctrl; // R22
      rx_code_error_flag_out   <= rx_is_err;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rx_word_strobe_out <= 1'b0;
      rx_locked_out      <= 1'b0;
    end else begin
      rx_word_strobe_out <= rx_word_done;
      rx_locked_out      <= rx_locked;
    end
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  logic [31:0] status_word;
  wire logic apb_setup  = psel_in && !penable_in;
  wire logic apb_access = psel_in && penable_in;
  wire logic hit_ctrl   = (paddr_in == cilc_pkg::ADDR_CTRL);
  wire logic hit_status = (paddr_in == cilc_pkg::ADDR_STATUS);
  wire logic [31:0] read_word = hit_ctrl ? {24'h000000, ctrl} : (hit_status ? status_word : 32'h00000000);

  always_comb begin
    status_word = 32'h00000000;
    status_word[cilc_pkg::ST_LOCKED]   = rx_locked;
    status_word[cilc_pkg::ST_ACC_SIGN] = accumulated_sign;
    status_word[cilc_pkg::ST_DATA]     = rx_data_word_flag_out;
    status_word[cilc_pkg::ST_CTRL]     = rx_control_word_flag_out;
    status_word[cilc_pkg::ST_ERR]      = rx_code_error_flag_out;
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access && !hit_ctrl && !hit_status;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl       <= cilc_pkg::CTRL_RESET;
      prdata_out <= 32'h00000000;
    end else begin
      if (apb_access && pwrite_in && hit_ctrl) begin
        ctrl <= pwdata_in[7:0];
      end
      if (apb_setup && !pwrite_in) begin
        prdata_out <= read_word;
      end
    end
  end

  // checks
  sequence s_toggle_load;
    tx_load && tx_sel_data && !tx_user_flag_enable;
  endsequence
  sequence s_idle_load;
    tx_load && tx_sel_idle;
  endsequence
  sequence s_lock_step;
    !rx_locked ##1 rx_locked;
  endsequence

  a_oe_toggles: assert property (s_toggle_load |=> tx_toggle != $past(tx_toggle)) // R10
    else $error("odd/even bit did not toggle on a data word");
  a_user_flag_copy: assert property ( // R9
    (tx_sel_data && tx_user_flag_enable && !enhanced_simplex_enable) |-> tx_flag == tx_extra_bit_in)
    else $error("flag does not follow the extra bit");
  a_idle_not_inverted: assert property (s_idle_load |=> !tx_last_invert && tx_last_idle) // R8
    else $error("idle word was inverted");
  a_idle_type_pick: assert property (s_idle_load |=> tx_shift[15:1] == ($past(accumulated_sign) // R6
    ? cilc_pkg::IDLE_B_FIELD[15:1] : cilc_pkg::IDLE_A_FIELD[15:1]))
    else $error("wrong idle type for the accumulated sign");
  a_invert_rule: assert property ((tx_load && !tx_sel_idle) // R7
    |=> tx_last_invert == ($past(tx_word_sign) == $past(accumulated_sign)))
    else $error("inversion decision wrong");
  a_first_bit_out: assert property (tx_load |=> serial_line_out == $past(tx_sent[0])) // R25
    else $error("word did not start with w0");
  a_frame_length: assert property (tx_bit_count <= cilc_pkg::LAST_BIT && rx_bit_count <= cilc_pkg::LAST_BIT) // R2
    else $error("bit counter ran past twenty bits");
  a_lock_needs_ref: assert property (s_lock_step |-> $past(rx_ref_rise)) // R18
    else $error("lock without a reference edge");
  a_code_error: assert property ((rx_word_done && rx_bad_c12) |=> rx_code_error_flag_out && rx_word_strobe_out) // R23
    else $error("illegal coding field not flagged");
  a_rx_one_kind: assert property (!(rx_data_word_flag_out && rx_control_word_flag_out) // R22
    && !(rx_code_error_flag_out && (rx_data_word_flag_out || rx_control_word_flag_out)))
    else $error("more than one word kind reported");
  a_ctrl_realign: assert property (rx_control_word_flag_out |-> rx_data_out[15:14] == 2'h0) // R21
    else $error("control word upper bits not cleared");
  a_flag_data_only: assert property (!rx_data_word_flag_out |-> !rx_flag_out) // R11
    else $error("flag shown on a non-data word");
endmodule : cilc_codec

// ===== cilc_line_rx.sv
// far-end receiver model: collects the transmit line into 20-bit frames
module cilc_line_rx (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        strobe_in,
  input  wire logic        serial_in,
  input  wire logic        en_in,
  input  wire logic [2:0]  div_in,
  output logic             loop_out,
  output logic      [19:0] frame_out,
  output logic             frame_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   k = 9999;
  int   n;
  logic act = 1'h0;
  assign n = int'(div_in);
  assign loop_out = serial_in;
  always @(posedge clk_sys_in) begin
    k <= reset_in ? 9999 : strobe_in ? 0 : k + 1;
    if (strobe_in) act <= en_in;
  end
  // mid-bit sampling on the falling edge, clear of the launching edge
  always @(negedge clk_sys_in) begin
    frame_valid_out <= act && k == 19 * n + n / 2;
    if (k % n == n / 2 && k / n < 20) frame_out[k / n] <= serial_in;
  end
endmodule : cilc_line_rx

// ===== cilc_codec_bench.sv
// self-checking bench: apb setup, random words per range, frame compare
module cilc_codec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'h0, reset_in = 1'h1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, e;
  logic [31:0] pwdata = 32'h0, prdata, q, cw;
  logic [15:0] txd = 16'h0, rx_dout;
  logic        dv = 1'h0, cv = 1'h0, xb = 1'h0, en = 1'h0;
  logic        local_reference_clock = 1'h0, rx_en = 1'h0, xclk = 1'h0, strobe, sline, loop, locked, fvalid;
  logic        rxs, rx_fl, rx_dv, rx_cv, rx_er;
  logic [19:0] frame;
  logic [2:0]  div = 3'h1;
  logic [19:0] expq[$], rxq[$];
  int          err_total = 0, comparisons = 0, cyc = 0, disp = 0;
  bit          seeded = 1'h0;

  cilc_codec cilc_codec_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .tx_data_in(txd), .tx_data_word_valid_in(dv), .tx_control_word_valid_in(cv),
    .tx_extra_bit_in(xb), .tx_word_clock_in(xclk), .tx_word_strobe_out(strobe), .serial_line_out(sline),
    .serial_line_in(loop), .local_reference_clock_in(local_reference_clock), .rx_test_serial_clock_in(1'h0),
    .rx_data_out(rx_dout), .rx_flag_out(rx_fl), .rx_data_word_flag_out(rx_dv), .rx_control_word_flag_out(rx_cv),
    .rx_code_error_flag_out(rx_er), .rx_word_strobe_out(rxs), .rx_locked_out(locked));
  cilc_line_rx cilc_line_rx_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .strobe_in(strobe),
    .serial_in(sline), .en_in(en), .div_in(div), .loop_out(loop), .frame_out(frame), .frame_valid_out(fvalid));

  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic report_and_stop;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons = comparisons + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_in);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge clk_sys_in);
    penable <= 1'h1;
    do @(posedge clk_sys_in); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wait_strobe;
    do @(posedge clk_sys_in); while (strobe !== 1'h1);
  endtask : wait_strobe

  // word clock pin and hang guard; a stuck handshake ends here
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    xclk <= ~xclk;
    if (cyc > 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  // note the frame due for the word captured at this edge, then offer the next
  always @(posedge clk_sys_in) begin
    logic [15:0] wf;
    logic [3:0]  cf;
    logic [19:0] w;
    if (!seeded) void'($urandom(64));
    seeded = 1'h1;
    if (reset_in) disp = 0;
    if (strobe === 1'h1) begin
      wf = dv ? txd : cv ? {txd[13:7], 2'h2, txd[6:0]} : disp > 0 ? 16'h007F : 16'h01FF;
      cf = dv ? (xb ? 4'hB : 4'hD) : 4'h3;
      w = {cf[0], cf[1], cf[2], cf[3], wf};
      if ((dv | cv) && (($countones(w) > 10) == (disp > 0))) w = ~w;
      disp = disp + 2 * $countones(w) - 20;
      if (en) expq.push_back(w);
      if (rx_en) rxq.push_back({1'h0, cv & !dv, dv, dv & xb, dv ? txd : cv ? {2'h0, txd[13:0]} : 16'h0000});
      txd <= 16'($urandom);
      {cv, dv} <= 2'($urandom);
      xb <= 1'($urandom);
    end
  end

  always @(posedge clk_sys_in) begin
    if (fvalid === 1'h1 && expq.size() == 0) chk("frame count", 32'h1, 32'h0);
    else if (fvalid === 1'h1) chk("frame", expq.pop_front(), frame);
    if (rxs === 1'h1 && rxq.size() == 0) chk("rx count", 32'h1, 32'h0);
    else if (rxs === 1'h1) chk("rx word", rxq.pop_front(), {rx_er, rx_cv, rx_dv, rx_fl, rx_dout});
  end

  initial begin
    for (int i = 0; i < 4; i++) begin
      reset_in <= 1'h1;
      repeat (i == 0 ? 20 : 4) @(posedge clk_sys_in);
      expq.delete();
      reset_in <= 1'h0;
      div <= i[1] ? 3'h4 : i[0] ? 3'h2 : 3'h1;
      // last round runs from the word clock pin, one rise per two cycles, divided by two
      cw = i == 3 ? 32'h16 : 32'h2 | (32'(i) << 4);
      apb(8'h00, 1'h1, cw);
      apb(8'h00, 1'h0, 32'h0);
      chk("ctrl", cw, q);
      wait_strobe();
      wait_strobe();
      en <= 1'h1;
      repeat (12) wait_strobe();
      en <= 1'h0;
      repeat (100) @(posedge clk_sys_in);
      chk("pending", 32'h0, expq.size());
    end
    chk("locked idle ref", 32'h0, locked);
    apb(8'h00, 1'h1, 32'h2);
    repeat (7) begin
      local_reference_clock <= 1'h1;
      repeat (3) @(posedge clk_sys_in);
      local_reference_clock <= 1'h0;
      repeat (3) @(posedge clk_sys_in);
    end
    chk("locked early", 32'h0, locked);
    // eighth rise timed so the first sampled bit is w0 of the next word
    wait_strobe();
    repeat (19) @(posedge clk_sys_in);
    local_reference_clock <= 1'h1;
    rx_en <= 1'h1;
    repeat (200) if (locked !== 1'h1) @(posedge clk_sys_in);
    chk("locked", 32'h1, locked);
    repeat (8) wait_strobe();
    rx_en <= 1'h0;
    apb(8'h04, 1'h0, 32'h0);
    chk("status lock", 32'h1, q[0]);
    apb(8'h08, 1'h0, 32'h0);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
    repeat (30) @(posedge clk_sys_in);
    chk("rx pending", 32'h0, rxq.size());
    report_and_stop();
  end
endmodule : cilc_codec_bench
